// ### iep_pkg.sv
// Package with register map, field positions and reset values of the interrupt enable and page block
package iep_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses on the APB
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_IE = 12'h000;
  localparam logic [11:0] ADDR_PAGE_CTL = 12'h004;
  localparam logic [11:0] ADDR_PAGE_SEL = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_PORT0 = 12'h010;
  localparam logic [11:0] ADDR_PORT_STEP = 12'h004;
  localparam logic [11:0] ADDR_BANK = 12'h020;

  // ----------------------------------------------------------------
  // Interrupt enable register fields
  // ----------------------------------------------------------------
  localparam int IE_GLOBAL_BIT = 7;
  localparam int IE_GP_BIT = 6;
  localparam int IE_T2_BIT = 5;
  localparam int IE_U0_BIT = 4;
  localparam int IE_T1_BIT = 3;
  localparam int IE_X1_BIT = 2;
  localparam int IE_T0_BIT = 1;
  localparam int IE_X0_BIT = 0;
  localparam logic [7:0] IE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Page control, page select and status fields
  // ----------------------------------------------------------------
  localparam int PAGE_CTL_AUTO_BIT = 0;
  localparam logic PAGE_AUTO_RESET = 1'b1;
  localparam int PAGE_W = 4;
  localparam int NUM_PAGES = 16;
  localparam logic [3:0] PAGE_RESET = 4'h0;
  localparam int NUM_SRC = 6;
  localparam int NUM_PORTS = 4;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam int ST_PAGE_LSB = 0;
  localparam int ST_SAVED_LSB = 4;
  localparam int ST_INSVC_BIT = 8;
  localparam int ST_SRC_LSB = 9;
  localparam int ST_PEND_LSB = 12;

  // Page each source switches to when taken, index equals mask bit position
  localparam logic [5:0][3:0] SRC_PAGE = {4'h2, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0};

endpackage

// ### iep_page_mem.sv
// Paged register bank: one byte per page, registered read data
`timescale 1ns/100ps
module iep_page_mem
  import iep_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] rdPage,
  input wire logic wrEn,
  input wire logic [3:0] wrPage,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData
);

  logic [7:0] mem [NUM_PAGES];
  logic [7:0] rdData_ff;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset on the array keeps it a plain memory
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrPage] <= wrData;
    end
  end

  // Write-first so a read right after a write is never stale
  always_ff @(posedge clk)
  begin
    if (wrEn && (wrPage == rdPage))
    begin
      rdData_ff <= wrData;
    end
    else
    begin
      rdData_ff <= mem[rdPage];
    end
  end

  assign rdData = rdData_ff;

endmodule

// ### iep_ctrl.sv
// Interrupt enable gating, automatic page switching and all-page decode behind an APB slave
`timescale 1ns/100ps
module iep_ctrl
  import iep_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irqTimer0,
  input wire logic irqTimer1,
  input wire logic irqTimer2,
  input wire logic irqUart0,
  input wire logic extIrq0Pin,
  input wire logic extIrq1Pin,
  input wire logic irqReturn,
  output logic irqTaken,
  output logic [2:0] irqSource,
  output logic irqInService,
  output logic [3:0] pageSel,
  output logic [7:0] portOut0,
  output logic [7:0] portOut1,
  output logic [7:0] portOut2,
  output logic [7:0] portOut3
);

  typedef enum logic [2:0] {REG_IE, REG_PCTL, REG_PSEL, REG_STAT, REG_PORT, REG_BANK, REG_NONE} iep_reg_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Port registers decode on address alone, the page select never enters
  function automatic iep_reg_t decodeReg(input logic [11:0] addr);
    iep_reg_t sel;
    sel = REG_NONE;
    if (addr == ADDR_IE) sel = REG_IE;
    else if (addr == ADDR_PAGE_CTL) sel = REG_PCTL;
    else if (addr == ADDR_PAGE_SEL) sel = REG_PSEL;
    else if (addr == ADDR_STATUS) sel = REG_STAT;
    else if ((addr >= ADDR_PORT0) && (addr < ADDR_BANK) && (addr[1:0] == 2'b00)) sel = REG_PORT;
    else if (addr == ADDR_BANK) sel = REG_BANK;
    return sel;
  endfunction

  // Lowest mask position wins, the classic fixed order
  function automatic logic [2:0] pickSource(input logic [5:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i]) idx = 3'(i);
    end
    return idx;
  endfunction

  logic [7:0] ieReg_ff;
  logic pageAuto_ff;
  logic [3:0] pageSel_ff;
  logic [3:0] nxt_pageSel;
  logic [3:0] savedPage_ff;
  logic inService_ff;
  logic [2:0] source_ff;
  logic taken_ff;
  logic [7:0] portReg_ff [NUM_PORTS];
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [1:0] ext0Sync_ff;
  logic [1:0] ext1Sync_ff;
  logic [5:0] rawReq;
  logic [5:0] gatedReq;
  logic takeNow;
  logic [2:0] takeSrc;
  logic [3:0] takePage;
  logic setupPhase;
  logic wrDone;
  iep_reg_t setupReg;
  iep_reg_t accessReg;
  logic [1:0] portIdx;
  logic [1:0] accessPortIdx;
  logic [7:0] bankRdData;
  logic bankWr;

  // ----------------------------------------------------------------
  // External inputs come from pins and pass two flops first
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext0Sync_ff <= 2'b00;
      ext1Sync_ff <= 2'b00;
    end
    else
    begin
      ext0Sync_ff <= {ext0Sync_ff[0], extIrq0Pin};
      ext1Sync_ff <= {ext1Sync_ff[0], extIrq1Pin};
    end
  end

  // ----------------------------------------------------------------
  // Request gating
  // ----------------------------------------------------------------
  // Bit 6 is deliberately left out of the gate
  assign rawReq = {irqTimer2, irqUart0, irqTimer1, ext1Sync_ff[1], irqTimer0, ext0Sync_ff[1]};
  assign gatedReq[IE_T2_BIT] = rawReq[IE_T2_BIT] & ieReg_ff[IE_T2_BIT] & ieReg_ff[IE_GLOBAL_BIT];
  assign gatedReq[IE_U0_BIT] = rawReq[IE_U0_BIT] & ieReg_ff[IE_U0_BIT] & ieReg_ff[IE_GLOBAL_BIT];
  assign gatedReq[IE_T1_BIT] = rawReq[IE_T1_BIT] & ieReg_ff[IE_T1_BIT] & ieReg_ff[IE_GLOBAL_BIT];
  assign gatedReq[IE_X1_BIT] = rawReq[IE_X1_BIT] & ieReg_ff[IE_X1_BIT] & ieReg_ff[IE_GLOBAL_BIT];
  assign gatedReq[IE_T0_BIT] = rawReq[IE_T0_BIT] & ieReg_ff[IE_T0_BIT] & ieReg_ff[IE_GLOBAL_BIT];
  assign gatedReq[IE_X0_BIT] = rawReq[IE_X0_BIT] & ieReg_ff[IE_X0_BIT] & ieReg_ff[IE_GLOBAL_BIT];
  assign takeNow = !inService_ff && (|gatedReq);
  assign takeSrc = pickSource(gatedReq);
  assign takePage = SRC_PAGE[takeSrc];

  // ----------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------
  assign setupPhase = psel && !penable;
  assign wrDone = psel && penable && pready_ff && pwrite;
  assign setupReg = decodeReg(paddr);
  assign accessReg = decodeReg(paddr);
  assign portIdx = 2'((paddr - ADDR_PORT0) >> 2);
  assign accessPortIdx = portIdx;
  assign bankWr = wrDone && (accessReg == REG_BANK);

  // ----------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------
  // Whole byte is stored, bit 6 simply reads back
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ieReg_ff <= IE_RESET;
    end
    else if (wrDone && (accessReg == REG_IE))
    begin
      ieReg_ff <= pwdata[7:0];
    end
  end

  // Auto page control, set at reset until software clears it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pageAuto_ff <= PAGE_AUTO_RESET;
    end
    else if (wrDone && (accessReg == REG_PCTL))
    begin
      pageAuto_ff <= pwdata[PAGE_CTL_AUTO_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Service state and page stack
  // ----------------------------------------------------------------
  // A take outranks a software page write in the same cycle
  always_comb
  begin
    nxt_pageSel = pageSel_ff;
    if (takeNow && pageAuto_ff)
    begin
      nxt_pageSel = takePage;
    end
    else if (irqReturn && inService_ff && pageAuto_ff)
    begin
      nxt_pageSel = savedPage_ff;
    end
    else if (wrDone && (accessReg == REG_PSEL))
    begin
      nxt_pageSel = pwdata[PAGE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pageSel_ff <= PAGE_RESET;
      savedPage_ff <= PAGE_RESET;
    end
    else
    begin
      pageSel_ff <= nxt_pageSel;
      if (takeNow && pageAuto_ff)
      begin
        savedPage_ff <= (wrDone && (accessReg == REG_PSEL)) ? pwdata[PAGE_W-1:0] : pageSel_ff;
      end
    end
  end

  // One level of service; the return pulse closes it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      inService_ff <= 1'b0;
      source_ff <= 3'h0;
      taken_ff <= 1'b0;
    end
    else
    begin
      taken_ff <= takeNow;
      if (takeNow)
      begin
        inService_ff <= 1'b1;
        source_ff <= takeSrc;
      end
      else if (irqReturn)
      begin
        inService_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // All-page port registers
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        portReg_ff[p] <= PORT_RESET;
      end
      else if (wrDone && (accessReg == REG_PORT) && (accessPortIdx == 2'(p)))
      begin
        portReg_ff[p] <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Paged byte, one per page
  // ----------------------------------------------------------------
  iep_page_mem u_page_mem (
    .clk(clk),
    .rdPage(nxt_pageSel),
    .wrEn(bankWr),
    .wrPage(pageSel_ff),
    .wrData(pwdata[7:0]),
    .rdData(bankRdData)
  );

  // ----------------------------------------------------------------
  // APB answer, zero wait: ready in the first access cycle
  // ----------------------------------------------------------------
  // Unmapped addresses answer zero with an error
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= setupPhase;
      pslverr_ff <= setupPhase && (setupReg == REG_NONE);
      prdata_ff <= 32'h0000_0000;
      if (setupPhase && !pwrite)
      begin
        unique case (setupReg)
          REG_IE: prdata_ff <= {24'h000000, ieReg_ff};
          REG_PCTL: prdata_ff <= {31'h0, pageAuto_ff};
          REG_PSEL: prdata_ff <= {28'h0, pageSel_ff};
          REG_STAT: prdata_ff <= {14'h0, gatedReq, source_ff, inService_ff, savedPage_ff, pageSel_ff};
          REG_PORT: prdata_ff <= {24'h000000, portReg_ff[portIdx]};
          REG_BANK: prdata_ff <= {24'h000000, bankRdData};
          REG_NONE: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irqTaken = taken_ff;
  assign irqSource = source_ff;
  assign irqInService = inService_ff;
  assign pageSel = pageSel_ff;
  assign portOut0 = portReg_ff[0];
  assign portOut1 = portReg_ff[1];
  assign portOut2 = portReg_ff[2];
  assign portOut3 = portReg_ff[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence sTakeAuto;
    takeNow && pageAuto_ff;
  endsequence

  sequence sPortRead;
    setupPhase && !pwrite && (paddr == ADDR_PORT0);
  endsequence

  chk_global_gate: assert property (@(posedge clk) disable iff (!rstn)
    !ieReg_ff[IE_GLOBAL_BIT] |=> !irqTaken) else $error("interrupt taken with global enable low");
  chk_mask_t2: assert property (@(posedge clk) disable iff (!rstn)
    irqTaken && irqSource == 3'h5 |-> $past(ieReg_ff[IE_T2_BIT])) else $error("timer 2 taken while masked");
  chk_mask_uart0: assert property (@(posedge clk) disable iff (!rstn)
    irqTaken && irqSource == 3'h4 |-> $past(ieReg_ff[IE_U0_BIT])) else $error("uart 0 taken while masked");
  chk_mask_t1: assert property (@(posedge clk) disable iff (!rstn)
    irqTaken && irqSource == 3'h3 |-> $past(ieReg_ff[IE_T1_BIT])) else $error("timer 1 taken while masked");
  chk_mask_ext1: assert property (@(posedge clk) disable iff (!rstn)
    irqTaken && irqSource == 3'h2 |-> $past(ieReg_ff[IE_X1_BIT])) else $error("external 1 taken while masked");
  chk_mask_t0: assert property (@(posedge clk) disable iff (!rstn)
    irqTaken && irqSource == 3'h1 |-> $past(ieReg_ff[IE_T0_BIT])) else $error("timer 0 taken while masked");
  chk_mask_ext0: assert property (@(posedge clk) disable iff (!rstn)
    irqTaken && irqSource == 3'h0 |-> $past(ieReg_ff[IE_X0_BIT])) else $error("external 0 taken while masked");
  chk_auto_switch: assert property (@(posedge clk) disable iff (!rstn)
    sTakeAuto |=> pageSel_ff == $past(takePage) && irqTaken) else $error("page not switched on take");
  chk_auto_default: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> pageAuto_ff) else $error("auto page control not set after reset");
  chk_port_allpage: assert property (@(posedge clk) disable iff (!rstn)
    sPortRead |=> pready && !pslverr && prdata[7:0] == portReg_ff[0]) else $error("port read depends on page");
  chk_gp_store: assert property (@(posedge clk) disable iff (!rstn)
    wrDone && paddr == ADDR_IE |=> ieReg_ff[IE_GP_BIT] == $past(pwdata[IE_GP_BIT])) else $error("flag bit not stored");

endmodule

// ### test_interrupt_enable_sfr_paging.sv
// Self-checking bench for the interrupt enable and register page block
`timescale 1ns/100ps
module test_interrupt_enable_sfr_paging
  import iep_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [5:0] reqVec = 6'h00;
  logic irqReturn = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irqTaken, irqInService;
  logic [2:0] irqSource;
  logic [3:0] pageSel;
  logic [7:0] portOut0, portOut1, portOut2, portOut3;
  int n_mismatch = 0;
  int n_compared = 0;
  // Expected APB results {write, error, data} and taken interrupts {source, page}
  logic [33:0] expApb[$];
  logic [6:0] expIrq[$];

  // ----------------------------------------------------------------
  // Clock and design
  // ----------------------------------------------------------------
  always #20 clk = ~clk;

  iep_ctrl dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqTimer0(reqVec[1]),
    .irqTimer1(reqVec[3]), .irqTimer2(reqVec[5]), .irqUart0(reqVec[4]), .extIrq0Pin(reqVec[0]),
    .extIrq1Pin(reqVec[2]), .irqReturn(irqReturn), .irqTaken(irqTaken), .irqSource(irqSource),
    .irqInService(irqInService), .pageSel(pageSel), .portOut0(portOut0), .portOut1(portOut1),
    .portOut2(portOut2), .portOut3(portOut3));

  // ----------------------------------------------------------------
  // Compare and report tasks
  // ----------------------------------------------------------------
  task automatic cmpApb(input logic [33:0] e);
    n_compared++;
    if (pslverr !== e[32] || (!e[33] && prdata !== e[31:0]))
    begin
      $display("[FAIL] apb %h expected %h/%h seen %h/%h", paddr, e[32], e[31:0], pslverr, prdata);
      n_mismatch++;
    end
  endtask

  task automatic cmpIrq(input logic [6:0] e);
    n_compared++;
    if ({irqInService, irqSource, pageSel} !== {1'b1, e})
    begin
      $display("[FAIL] irq state expected %h seen %h", {1'b1, e}, {irqInService, irqSource, pageSel});
      n_mismatch++;
    end
  endtask

  // Port outputs are levels, so they are compared directly once settled
  task automatic cmpPort(input int i, input logic [7:0] e);
    logic [7:0] seen;
    seen = (i == 0) ? portOut0 : (i == 1) ? portOut1 : (i == 2) ? portOut2 : portOut3;
    n_compared++;
    if (seen !== e)
    begin
      $display("[FAIL] portOut%0d expected %h seen %h", i, e, seen);
      n_mismatch++;
    end
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic timeout(input string what);
    $display("[FAIL] %s expected 1 seen timeout", what);
    n_mismatch++;
    complete_run;
  endtask

  // Monitor: each completed transfer or taken interrupt consumes the oldest note
  always @(posedge clk)
  begin
    if (rstn && psel && penable && pready === 1'b1)
    begin
      if (expApb.size() == 0)
        timeout("apb note");
      else
        cmpApb(expApb.pop_front());
    end
    if (rstn && irqTaken === 1'b1)
    begin
      if (expIrq.size() == 0)
      begin
        $display("[FAIL] irqTaken expected 0 seen 1 source %h", irqSource);
        n_mismatch++;
      end
      else
        cmpIrq(expIrq.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Holds the request until pready is sampled high, then releases it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ed,
    input logic ee);
    int n;
    expApb.push_back({w, ee, ed});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      timeout("pready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h00000000, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed);
    apb(1'b0, a, 32'h00000000, ed, 1'b0);
  endtask

  // Raise one source; the ext pins pass a 2-flop synchroniser, so 8 cycles cover the latency
  task automatic trySrc(input int b, input logic [7:0] ie, input logic take, input logic [3:0] pg);
    int n;
    wr(ADDR_IE, {24'h000000, ie});
    if (take)
      expIrq.push_back({3'(b), pg});
    @(posedge clk);
    reqVec <= 6'h01 << b;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (irqTaken !== 1'b1 && n < 8);
    if (take && irqTaken !== 1'b1)
      timeout("irqTaken");
    reqVec <= 6'h00;
    // Let a dropped pin drain through the synchroniser before the return
    repeat (4) @(posedge clk);
    if (take)
    begin
      irqReturn <= 1'b1;
      @(posedge clk);
      irqReturn <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [3:0] pg;
    logic [7:0] ie;
    logic [7:0] d;
    logic g;
    void'($urandom(32'h15C7));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_IE, 32'h00000000);
    rd(ADDR_PAGE_CTL, 32'h00000001);
    rd(ADDR_PAGE_SEL, 32'h00000000);
    apb(1'b0, 12'h040, 32'h00000000, 32'h00000000, 1'b1);
    $display("test reset values done");
    for (int b = 0; b < NUM_SRC; b++)
    begin
      pg = 4'($urandom_range(15));
      g = 1'($urandom_range(1));
      wr(ADDR_PAGE_SEL, {28'h0000000, pg});
      trySrc(b, {1'b0, g, 6'h3F}, 1'b0, pg);
      trySrc(b, {1'b1, g, ~(6'h01 << b)}, 1'b0, pg);
      ie = {1'b1, g, 6'h01 << b};
      trySrc(b, ie, 1'b1, SRC_PAGE[b]);
      rd(ADDR_PAGE_SEL, {28'h0000000, pg});
      rd(ADDR_IE, {24'h000000, ie});
    end
    $display("test source gating done");
    wr(ADDR_PAGE_CTL, 32'h00000000);
    rd(ADDR_PAGE_CTL, 32'h00000000);
    wr(ADDR_PAGE_SEL, 32'h00000005);
    trySrc(4, 8'h90, 1'b1, 4'h5);
    rd(ADDR_PAGE_SEL, 32'h00000005);
    $display("test auto page off done");
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      pg = 4'($urandom_range(15));
      d = 8'($urandom_range(255));
      wr(ADDR_PAGE_SEL, {28'h0000000, pg});
      wr(ADDR_PORT0 + ADDR_PORT_STEP * 12'(i), {24'h000000, d});
      wr(ADDR_PAGE_SEL, {28'h0000000, ~pg});
      cmpPort(i, d);
      rd(ADDR_PORT0 + ADDR_PORT_STEP * 12'(i), {24'h000000, d});
    end
    $display("test all-page ports done");
    // The paged byte must follow the page select, unlike the ports
    wr(ADDR_PAGE_SEL, 32'h00000003);
    wr(ADDR_BANK, 32'h000000A5);
    wr(ADDR_PAGE_SEL, 32'h00000004);
    wr(ADDR_BANK, 32'h0000005A);
    rd(ADDR_BANK, 32'h0000005A);
    wr(ADDR_PAGE_SEL, 32'h00000003);
    rd(ADDR_BANK, 32'h000000A5);
    $display("test paged byte done");
    // Second reset in mid-run must bring auto switching back on
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_PAGE_CTL, 32'h00000001);
    rd(ADDR_IE, 32'h00000000);
    rd(ADDR_STATUS, 32'h00000000);
    for (int i = 0; i < NUM_PORTS; i++)
      cmpPort(i, PORT_RESET);
    $display("test second reset done");
    repeat (2) @(posedge clk);
    if (expIrq.size() != 0 || expApb.size() != 0)
      timeout("drained notes");
    complete_run;
  end
endmodule
